// File: design/iopc_defs.svh
// constants for the pad controller: register map, encodings, timing
// Functional notes
// - each pin push-pull, open-drain or input
// - per-pin pull-up and pull-down enables
// - per-pin switchable input de-bounce filter
// - per-pin level or edge interrupt detection
// - edge mode picks rising, falling or both
// - per-pin interrupt enable and sticky flag
// - per-pin eight-way peripheral multiplexer
// - analog input bypasses the multiplexer
// - selection zero is plain gpio function
// - analog-capable pins in analog mode drop the digital path
// - per-pin drive strength, eight settings
`ifndef IOPC_DEFS_SVH
`define IOPC_DEFS_SVH

`define IOPC_NPINS 8
`define IOPC_ADDR_W 8

// register byte offsets
`define IOPC_OFS_DOUT 8'h00
`define IOPC_OFS_MODE 8'h04
`define IOPC_OFS_PULLUP 8'h08
`define IOPC_OFS_PULLDN 8'h0c
`define IOPC_OFS_DBEN 8'h10
`define IOPC_OFS_ITYPE 8'h14
`define IOPC_OFS_ISEL 8'h18
`define IOPC_OFS_IEN 8'h1c
`define IOPC_OFS_IFLAG 8'h20
`define IOPC_OFS_DIN 8'h24
`define IOPC_OFS_MUX 8'h28
`define IOPC_OFS_DS 8'h2c

// pin mode encoding, two bits per pin
`define IOPC_MODE_INPUT 2'h0
`define IOPC_MODE_PUSHPULL 2'h1
`define IOPC_MODE_OPENDRAIN 2'h2
`define IOPC_MODE_ANALOG 2'h3

// interrupt select, two bits per pin
`define IOPC_ISEL_RISE 2'h1
`define IOPC_ISEL_FALL 2'h2
`define IOPC_ISEL_BOTH 2'h3

// reset values and analog-capable pin mask
`define IOPC_MUX_SELECTION_ZERO 3'h0
`define IOPC_DS_RESET 3'h0
`define IOPC_ANALOG_MASK 8'hf0

// de-bounce timing
`define IOPC_CLK_PERIOD_NS 10
`define IOPC_DB_TIME_NS 80
`define IOPC_DB_CYCLES ((`IOPC_DB_TIME_NS + `IOPC_CLK_PERIOD_NS - 1) / `IOPC_CLK_PERIOD_NS)

`endif

// File: design/iopc_pkg.sv
// shared types of the pad controller
package iopc_pkg;
    typedef logic [1:0] iopc_mode_type;
    typedef logic [2:0] iopc_sel_type;
    typedef logic [2:0] iopc_ds_type;
    typedef logic [1:0] iopc_isel_type;
endpackage

// File: design/iopc_pad_if.sv
// pad configuration and drive between controller and multiplexer
`timescale 1ns/1ns
interface iopc_pad_if #(parameter int NPINS = 8);
    logic [2*NPINS-1:0] mode;
    logic [NPINS-1:0] analog;
    logic [3*NPINS-1:0] mux_sel;
    logic [NPINS-1:0] gpio_do;
    logic [NPINS-1:0] pad_do;
    logic [NPINS-1:0] pad_oe;
    modport ctrl (output mode, output analog, output mux_sel, output gpio_do,
                  input pad_do, input pad_oe);
    modport mux (input mode, input analog, input mux_sel, input gpio_do,
                 output pad_do, output pad_oe);
endinterface

// File: design/iopc_debounce.sv
// input synchroniser and per-pin de-bounce filter
`timescale 1ns/1ns
`include "iopc_defs.svh"
module iopc_debounce #(
    parameter int NPINS = 8,
    parameter int DB_CYCLES = `IOPC_DB_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins and control
    input wire logic [NPINS-1:0] pad_di,
    input wire logic [NPINS-1:0] db_en,
    // filtered level
    output logic [NPINS-1:0] level
);
    localparam int CW = $clog2(DB_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(DB_CYCLES - 1);
    localparam int CNT_LAST_I = DB_CYCLES - 1;

    typedef struct packed {
        logic [NPINS-1:0] s1;
        logic [NPINS-1:0] s2;
        logic [NPINS-1:0] level;
        logic [NPINS-1:0][CW-1:0] cnt;
    } iopc_db_state_type;

    iopc_db_state_type r, nxt;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt = r;
        nxt.s1 = pad_di;
        nxt.s2 = r.s1;
        for (int i = 0; i < NPINS; i++) begin
            if (!db_en[i]) begin
                nxt.level[i] = r.s2[i];
                nxt.cnt[i] = '0;
            end else if (r.s2[i] == r.level[i]) begin
                nxt.cnt[i] = '0;
            end else if (r.cnt[i] == CNT_LAST) begin
                nxt.level[i] = r.s2[i];
                nxt.cnt[i] = '0;
            end else begin
                nxt.cnt[i] = r.cnt[i] + CW'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign level = r.level;

    ////////////////////////////////////////////////////////////////////////
    a_db_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
        db_en[0] && $past(db_en[0]) && $changed(r.level[0])
        |-> $past(r.cnt[0]) == CNT_LAST_I)
        else $error("filtered level changed before the hold time");
endmodule

// File: design/iopc_mux.sv
// per-pin source multiplexer and output stage
`timescale 1ns/1ns
`include "iopc_defs.svh"
module iopc_mux #(
    parameter int NPINS = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // peripheral sources, eight per pin
    input wire logic [8*NPINS-1:0] per_do,
    input wire logic [8*NPINS-1:0] per_oe,
    // controller side
    iopc_pad_if.mux pads
);
    typedef struct packed {
        logic [NPINS-1:0] pad_do;
        logic [NPINS-1:0] pad_oe;
    } iopc_mux_state_type;

    iopc_mux_state_type r, nxt;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        iopc_pkg::iopc_sel_type sel;
        iopc_pkg::iopc_mode_type m;
        sel = '0;
        m = '0;
        nxt = r;
        for (int i = 0; i < NPINS; i++) begin
            sel = pads.mux_sel[3*i +: 3];
            m = pads.mode[2*i +: 2];
            if (sel == `IOPC_MUX_SELECTION_ZERO) begin
                nxt.pad_do[i] = pads.gpio_do[i];
                nxt.pad_oe[i] = (m == `IOPC_MODE_PUSHPULL) || (m == `IOPC_MODE_OPENDRAIN);
            end else begin
                nxt.pad_do[i] = per_do[8*i + int'(sel)];
                nxt.pad_oe[i] = per_oe[8*i + int'(sel)];
            end
            if (m == `IOPC_MODE_OPENDRAIN) begin
                nxt.pad_oe[i] = nxt.pad_oe[i] & ~nxt.pad_do[i];
                nxt.pad_do[i] = 1'b0;
            end
            if (pads.analog[i]) begin
                nxt.pad_do[i] = 1'b0;
                nxt.pad_oe[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign pads.pad_do = r.pad_do;
    assign pads.pad_oe = r.pad_oe;
endmodule

// File: design/iopc_top.sv
// pad controller: apb registers, interrupt detect, pad drive
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
`include "iopc_defs.svh"
module iopc_top #(
    parameter int NPINS = `IOPC_NPINS,
    parameter logic [NPINS-1:0] ANALOG_MASK = `IOPC_ANALOG_MASK
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`IOPC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pads
    input wire logic [NPINS-1:0] pad_di,
    output logic [NPINS-1:0] pad_do,
    output logic [NPINS-1:0] pad_oe,
    output logic [NPINS-1:0] pad_pu,
    output logic [NPINS-1:0] pad_pd,
    output logic [3*NPINS-1:0] drive_strength_select,
    output logic [NPINS-1:0] analog_en,
    // peripherals
    input wire logic [8*NPINS-1:0] per_do,
    input wire logic [8*NPINS-1:0] per_oe,
    output logic [NPINS-1:0] per_di,
    // interrupt request
    output logic irq
);
    typedef struct packed {
        logic [NPINS-1:0] dout;
        logic [2*NPINS-1:0] mode;
        logic [NPINS-1:0] pu;
        logic [NPINS-1:0] pd;
        logic [NPINS-1:0] dben;
        logic [NPINS-1:0] itype;
        logic [2*NPINS-1:0] isel;
        logic [NPINS-1:0] ien;
        logic [NPINS-1:0] iflag;
        logic [3*NPINS-1:0] mux;
        logic [3*NPINS-1:0] ds;
        logic [NPINS-1:0] prev;
        logic irq;
        logic [31:0] prdata;
    } iopc_top_state_type;

    iopc_top_state_type r, nxt;
    logic [NPINS-1:0] level;
    logic [NPINS-1:0] analog_eff;
    logic [NPINS-1:0] din_eff;
    logic [NPINS-1:0] ev;
    logic hit;
    logic wr;
    logic [31:0] rd;

    iopc_pad_if #(.NPINS(NPINS)) pads ();

    ////////////////////////////////////////////////////////////////////////
    iopc_debounce #(.NPINS(NPINS)) u_db (
        .pclk(pclk),
        .presetn(presetn),
        .pad_di(pad_di),
        .db_en(r.dben),
        .level(level)
    );

    iopc_mux #(.NPINS(NPINS)) u_mux (
        .pclk(pclk),
        .presetn(presetn),
        .per_do(per_do),
        .per_oe(per_oe),
        .pads(pads)
    );

    ////////////////////////////////////////////////////////////////////////
    // analog pins and digital input
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            analog_eff[i] = (r.mode[2*i +: 2] == `IOPC_MODE_ANALOG) && ANALOG_MASK[i];
        end
    end

    assign din_eff = level & ~analog_eff;

    // event detection
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (r.itype[i]) begin
                ev[i] = (r.isel[2*i] & din_eff[i] & ~r.prev[i])
                      | (r.isel[2*i+1] & ~din_eff[i] & r.prev[i]);
            end else begin
                ev[i] = (r.isel[2*i] & din_eff[i])
                      | (r.isel[2*i+1] & ~din_eff[i]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    always_comb begin
        hit = 1'b1;
        rd = '0;
        case (paddr)
            `IOPC_OFS_DOUT: rd[NPINS-1:0] = r.dout;
            `IOPC_OFS_MODE: rd[2*NPINS-1:0] = r.mode;
            `IOPC_OFS_PULLUP: rd[NPINS-1:0] = r.pu;
            `IOPC_OFS_PULLDN: rd[NPINS-1:0] = r.pd;
            `IOPC_OFS_DBEN: rd[NPINS-1:0] = r.dben;
            `IOPC_OFS_ITYPE: rd[NPINS-1:0] = r.itype;
            `IOPC_OFS_ISEL: rd[2*NPINS-1:0] = r.isel;
            `IOPC_OFS_IEN: rd[NPINS-1:0] = r.ien;
            `IOPC_OFS_IFLAG: rd[NPINS-1:0] = r.iflag;
            `IOPC_OFS_DIN: rd[NPINS-1:0] = din_eff;
            `IOPC_OFS_MUX: rd[3*NPINS-1:0] = r.mux;
            `IOPC_OFS_DS: rd[3*NPINS-1:0] = r.ds;
            default: hit = 1'b0;
        endcase
    end

    assign wr = psel && penable && pwrite && hit;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt = r;
        nxt.prev = din_eff;
        if (psel && !penable) begin
            nxt.prdata = rd;
        end
        if (wr) begin
            case (paddr)
                `IOPC_OFS_DOUT: nxt.dout = pwdata[NPINS-1:0];
                `IOPC_OFS_MODE: nxt.mode = pwdata[2*NPINS-1:0];
                `IOPC_OFS_PULLUP: nxt.pu = pwdata[NPINS-1:0];
                `IOPC_OFS_PULLDN: nxt.pd = pwdata[NPINS-1:0];
                `IOPC_OFS_DBEN: nxt.dben = pwdata[NPINS-1:0];
                `IOPC_OFS_ITYPE: nxt.itype = pwdata[NPINS-1:0];
                `IOPC_OFS_ISEL: nxt.isel = pwdata[2*NPINS-1:0];
                `IOPC_OFS_IEN: nxt.ien = pwdata[NPINS-1:0];
                `IOPC_OFS_MUX: nxt.mux = pwdata[3*NPINS-1:0];
                `IOPC_OFS_DS: nxt.ds = pwdata[3*NPINS-1:0];
                default: nxt.dout = r.dout;
            endcase
        end
        // write one clears, a new event wins
        if (wr && paddr == `IOPC_OFS_IFLAG) begin
            nxt.iflag = r.iflag & ~pwdata[NPINS-1:0];
        end
        nxt.iflag = nxt.iflag | ev;
        nxt.irq = |(nxt.iflag & nxt.ien);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.mux <= {NPINS{`IOPC_MUX_SELECTION_ZERO}};
            r.ds <= {NPINS{`IOPC_DS_RESET}};
        end else begin
            r <= nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; both pulls are passed as written
    assign pads.mode = r.mode;
    assign pads.analog = analog_eff;
    assign pads.mux_sel = r.mux;
    assign pads.gpio_do = r.dout;
    assign pad_do = pads.pad_do;
    assign pad_oe = pads.pad_oe;
    assign pad_pu = r.pu;
    assign pad_pd = r.pd;
    assign drive_strength_select = r.ds;
    assign analog_en = analog_eff;
    assign per_di = din_eff;
    assign irq = r.irq;
    assign prdata = r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_flag_sticky: assert property (
        r.iflag[0] && !(wr && paddr == `IOPC_OFS_IFLAG && pwdata[0]) |=> r.iflag[0])
        else $error("interrupt flag dropped without a clear");

    a_flag_clear: assert property (
        wr && paddr == `IOPC_OFS_IFLAG && pwdata[0] && !ev[0] |=> !r.iflag[0])
        else $error("write one did not clear the flag");

    a_level_reset: assert property (
        !r.itype[0] && r.isel[0] && din_eff[0] && wr && paddr == `IOPC_OFS_IFLAG
        |=> r.iflag[0])
        else $error("held level did not set the flag again");

    a_irq_gate: assert property (
        (r.iflag & r.ien) == '0 |-> !irq)
        else $error("interrupt raised with no enabled flag");

    a_rise_edge: assert property (
        r.itype[0] && r.isel[1:0] == `IOPC_ISEL_RISE && din_eff[0] && !r.prev[0]
        |=> r.iflag[0])
        else $error("rising edge missed");

    a_fall_only: assert property (
        r.itype[0] && r.isel[1:0] == `IOPC_ISEL_FALL && !r.iflag[0] && din_eff[0]
        && !(wr && paddr == `IOPC_OFS_ITYPE) && !(wr && paddr == `IOPC_OFS_ISEL)
        |=> !r.iflag[0])
        else $error("falling-only pin flagged on a high input");

    a_analog_quiet: assert property (
        analog_eff[4] [*2] |-> !pad_oe[4] && !pad_do[4])
        else $error("analog pin still driven");

    a_gpio_select: assert property (
        (r.mux[2:0] == `IOPC_MUX_SELECTION_ZERO && r.mode[1:0] == `IOPC_MODE_PUSHPULL) [*2]
        |-> pad_oe[0] && pad_do[0] == $past(r.dout[0]))
        else $error("selection zero not driving gpio data");

    a_periph_select: assert property (
        (r.mux[2:0] == 3'h3 && r.mode[1:0] == `IOPC_MODE_PUSHPULL) [*2]
        |-> pad_do[0] == $past(per_do[3]) && pad_oe[0] == $past(per_oe[3]))
        else $error("peripheral source not routed");

    a_od_no_high: assert property (
        (r.mode[1:0] == `IOPC_MODE_OPENDRAIN) [*2] |-> !(pad_oe[0] && pad_do[0]))
        else $error("open-drain pin drove high");

    a_drive_write: assert property (
        wr && paddr == `IOPC_OFS_DS
        |=> drive_strength_select == $past(pwdata[3*NPINS-1:0]))
        else $error("drive strength not updated");

    a_pull_write: assert property (
        wr && paddr == `IOPC_OFS_PULLUP |=> pad_pu == $past(pwdata[NPINS-1:0]))
        else $error("pull-up enable not updated");

    a_pulldn_write: assert property (
        wr && paddr == `IOPC_OFS_PULLDN |=> pad_pd == $past(pwdata[NPINS-1:0]))
        else $error("pull-down enable not updated");

    a_dout_write: assert property (
        wr && paddr == `IOPC_OFS_DOUT |=> r.dout == $past(pwdata[NPINS-1:0]))
        else $error("output data not updated");

    a_mode_write: assert property (
        wr && paddr == `IOPC_OFS_MODE |=> r.mode == $past(pwdata[2*NPINS-1:0]))
        else $error("pin mode not updated");

    a_dben_write: assert property (
        wr && paddr == `IOPC_OFS_DBEN |=> r.dben == $past(pwdata[NPINS-1:0]))
        else $error("filter enable not updated");

    a_itype_write: assert property (
        wr && paddr == `IOPC_OFS_ITYPE |=> r.itype == $past(pwdata[NPINS-1:0]))
        else $error("interrupt type not updated");

    a_isel_write: assert property (
        wr && paddr == `IOPC_OFS_ISEL |=> r.isel == $past(pwdata[2*NPINS-1:0]))
        else $error("interrupt select not updated");

    a_ien_write: assert property (
        wr && paddr == `IOPC_OFS_IEN |=> r.ien == $past(pwdata[NPINS-1:0]))
        else $error("interrupt enable not updated");

    a_mux_write: assert property (
        wr && paddr == `IOPC_OFS_MUX |=> r.mux == $past(pwdata[3*NPINS-1:0]))
        else $error("mux selection not updated");

    a_fall_edge: assert property (
        r.itype[0] && r.isel[1:0] == `IOPC_ISEL_FALL && !din_eff[0] && r.prev[0]
        |=> r.iflag[0])
        else $error("falling edge missed");

    a_both_edge: assert property (
        r.itype[0] && r.isel[1:0] == `IOPC_ISEL_BOTH && (din_eff[0] != r.prev[0])
        |=> r.iflag[0])
        else $error("edge missed in both-edge mode");

    a_rise_only: assert property (
        r.itype[0] && r.isel[1:0] == `IOPC_ISEL_RISE && !r.iflag[0] && !din_eff[0]
        |=> !r.iflag[0])
        else $error("rising-only pin flagged on a low input");

    a_level_high: assert property (
        !r.itype[0] && r.isel[0] && din_eff[0] |=> r.iflag[0])
        else $error("high level did not set the flag");

    a_level_low: assert property (
        !r.itype[0] && r.isel[1] && !din_eff[0] |=> r.iflag[0])
        else $error("low level did not set the flag");

    a_flag_no_enable: assert property (
        ev[0] && !r.ien[0] |=> r.iflag[0])
        else $error("flag not set while interrupt disabled");

    a_analog_din: assert property (
        analog_eff[4] |-> !per_di[4])
        else $error("analog pin feeds the digital input");

    a_nonanalog_pin: assert property (
        r.mode[1:0] == `IOPC_MODE_ANALOG |-> !analog_en[0])
        else $error("pin without analog capability in analog mode");

    a_od_drive_low: assert property (
        (r.mode[1:0] == `IOPC_MODE_OPENDRAIN && r.mux[2:0] == `IOPC_MUX_SELECTION_ZERO) [*2]
        |-> pad_oe[0] == !$past(r.dout[0]) && !pad_do[0])
        else $error("open-drain pin not pulling low for zero");

    a_input_hiz: assert property (
        (r.mode[1:0] == `IOPC_MODE_INPUT && r.mux[2:0] == `IOPC_MUX_SELECTION_ZERO) [*2]
        |-> !pad_oe[0])
        else $error("input pin driven");

    a_pu_hold: assert property (
        !(wr && paddr == `IOPC_OFS_PULLUP) |=> $stable(pad_pu))
        else $error("pull-up enable changed without a write");

    a_pd_hold: assert property (
        !(wr && paddr == `IOPC_OFS_PULLDN) |=> $stable(pad_pd))
        else $error("pull-down enable changed without a write");

    a_ds_hold: assert property (
        !(wr && paddr == `IOPC_OFS_DS) |=> $stable(drive_strength_select))
        else $error("drive strength changed without a write");

    a_mux_hold: assert property (
        !(wr && paddr == `IOPC_OFS_MUX) |=> $stable(r.mux))
        else $error("mux selection changed without a write");

    c_edge_irq: cover property (r.itype[0] && ev[0] && r.ien[0] ##1 irq);
    c_level_irq: cover property (!r.itype[0] && ev[0] ##1 r.iflag[0]);
    c_analog: cover property (analog_eff[4] [*3]);
    c_clear: cover property (r.iflag[0] ##1 !r.iflag[0]);
    c_od_release: cover property (r.mode[3:2] == `IOPC_MODE_OPENDRAIN && !pad_oe[1]);
endmodule

// File: tb/iopc_board.sv
// board model: resolves each pad line from drivers, pulls and outside sources
`timescale 1ns/1ns
module iopc_board #(
    parameter int NPINS = 8
) (
    // clock
    input wire logic pclk,
    // device side
    input wire logic [NPINS-1:0] pad_do,
    input wire logic [NPINS-1:0] pad_oe,
    input wire logic [NPINS-1:0] pad_pu,
    input wire logic [NPINS-1:0] pad_pd,
    // outside sources
    input wire logic [NPINS-1:0] ext_en,
    input wire logic [NPINS-1:0] ext_val,
    // resolved line
    output logic [NPINS-1:0] pad_line
);
    logic [NPINS-1:0] churn = '0;
    ////////////////////////////////////////////////////////////////////////////////
    // floating lines change every cycle
    always @(posedge pclk) begin
        churn <= ~churn;
    end
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (pad_oe[i]) begin
                pad_line[i] = pad_do[i];
            end else if (ext_en[i]) begin
                pad_line[i] = ext_val[i];
            end else if (pad_pu[i] || pad_pd[i]) begin
                pad_line[i] = pad_pu[i];
            end else begin
                pad_line[i] = churn[i];
            end
        end
    end
endmodule

// File: tb/iopc_tb.sv
// bench for the pad controller, register access over apb
`timescale 1ns/1ns
`include "iopc_defs.svh"
module iopc_tb;
    localparam logic [7:0] src_pat = 8'h96;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pad_di, pad_do, pad_oe, pad_pu, pad_pd, analog_en, per_di;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [23:0] drive_strength_select;
    logic [63:0] per_do = {8{src_pat}};
    logic [63:0] per_oe = {64{1'b1}};
    logic irq;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int n_checks = 0;
    always #5 pclk = ~pclk;
    iopc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_di(pad_di), .pad_do(pad_do),
        .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd),
        .drive_strength_select(drive_strength_select), .analog_en(analog_en),
        .per_do(per_do), .per_oe(per_oe), .per_di(per_di), .irq(irq));
    iopc_board board (.pclk(pclk), .pad_do(pad_do), .pad_oe(pad_oe), .pad_pu(pad_pu),
        .pad_pd(pad_pd), .ext_en(ext_en), .ext_val(ext_val), .pad_line(pad_di));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        results();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset state
        rchk("mux", `IOPC_OFS_MUX, 32'h0);
        rchk("ds", `IOPC_OFS_DS, 32'h0);
        rchk("mode", `IOPC_OFS_MODE, 32'h0);
        chk("oe", 32'h0, 32'(pad_oe));
        // pin0 push-pull, pin1 open-drain
        wr(`IOPC_OFS_MODE, 32'h9);
        wr(`IOPC_OFS_DOUT, 32'h1);
        cyc(3);
        chk("oe", 32'h3, 32'(pad_oe));
        chk("do", 32'h1, 32'(pad_do));
        wr(`IOPC_OFS_DOUT, 32'h3);
        cyc(3);
        chk("oe", 32'h1, 32'(pad_oe));
        // pulls on separate pins only
        wr(`IOPC_OFS_PULLUP, 32'h08);
        wr(`IOPC_OFS_PULLDN, 32'h20);
        cyc(6);
        chk("pu", 32'h08, 32'(pad_pu));
        chk("pd", 32'h20, 32'(pad_pd));
        apb(1'b0, `IOPC_OFS_DIN, 32'h0);
        chk("din", 32'h08, rd & 32'h28);
        // drive strength codes
        for (int k = 0; k < 8; k++) begin
            wr(`IOPC_OFS_DS, 32'({8{k[2:0]}}));
            cyc(3);
            chk("ds", 32'({8{k[2:0]}}), 32'(drive_strength_select));
        end
        // multiplexer sources of pin0
        for (int s = 0; s < 8; s++) begin
            wr(`IOPC_OFS_MUX, 32'(s));
            cyc(3);
            chk("mux_do", (s == 0) ? 32'h1 : 32'(src_pat[s]), 32'(pad_do[0]));
            rchk("mux", `IOPC_OFS_MUX, 32'(s));
        end
        // analog code on pin0 (not capable) and pin4
        wr(`IOPC_OFS_MUX, 32'h5000);
        wr(`IOPC_OFS_MODE, 32'h303);
        cyc(3);
        chk("analog", 32'h10, 32'(analog_en));
        chk("oe4", 32'h0, 32'(pad_oe[4]));
        chk("pdi4", 32'h0, 32'(per_di[4]));
        wr(`IOPC_OFS_MODE, 32'h0);
        // filter on pin2
        ext_en <= 8'h04;
        cyc(6);
        ext_val <= 8'h04;
        cyc(4);
        chk("pdi2", 32'h1, 32'(per_di[2]));
        wr(`IOPC_OFS_DBEN, 32'h4);
        ext_val <= 8'h00;
        cyc(3);
        ext_val <= 8'h04;
        cyc(12);
        chk("pdi2", 32'h1, 32'(per_di[2]));
        ext_val <= 8'h00;
        cyc(14);
        chk("pdi2", 32'h0, 32'(per_di[2]));
        wr(`IOPC_OFS_DBEN, 32'h0);
        // edge interrupts, each edge choice
        wr(`IOPC_OFS_ITYPE, 32'h4);
        wr(`IOPC_OFS_IEN, 32'h4);
        for (int e = 1; e < 4; e++) begin
            wr(`IOPC_OFS_ISEL, 32'(e) << 4);
            wr(`IOPC_OFS_IFLAG, 32'hff);
            ext_val <= 8'h04;
            cyc(6);
            chk("irq", 32'(e & 1), 32'(irq));
            rchk("flag", `IOPC_OFS_IFLAG, (e & 1) ? 32'h4 : 32'h0);
            wr(`IOPC_OFS_IFLAG, 32'h4);
            ext_val <= 8'h00;
            cyc(6);
            rchk("flag", `IOPC_OFS_IFLAG, (e & 2) ? 32'h4 : 32'h0);
        end
        // level interrupts
        wr(`IOPC_OFS_ITYPE, 32'h0);
        wr(`IOPC_OFS_ISEL, 32'h10);
        wr(`IOPC_OFS_IFLAG, 32'hff);
        rchk("flag", `IOPC_OFS_IFLAG, 32'h0);
        ext_val <= 8'h04;
        cyc(6);
        wr(`IOPC_OFS_IFLAG, 32'h4);
        rchk("flag", `IOPC_OFS_IFLAG, 32'h4);
        wr(`IOPC_OFS_IEN, 32'h0);
        cyc(2);
        chk("irq", 32'h0, 32'(irq));
        ext_val <= 8'h00;
        cyc(6);
        wr(`IOPC_OFS_IFLAG, 32'h4);
        rchk("flag", `IOPC_OFS_IFLAG, 32'h0);
        wr(`IOPC_OFS_ISEL, 32'h20);
        cyc(4);
        rchk("flag", `IOPC_OFS_IFLAG, 32'h4);
        // unmapped address
        apb(1'b0, 8'h40, 32'h0);
        chk("err", 32'h1, 32'(err));
        chk("rd", 32'h0, rd);
        results();
    end
endmodule
